// File: rp_event_pkg.sv
/*
 * Package for the root-port side-band event block: register offsets, field
 * positions, reset values, timing constants and the packed carriers.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package rp_event_pkg;
	localparam logic [11:0] CTRL_OFF     = 12'h000;
	localparam logic [11:0] STATUS_OFF   = 12'h004;
	localparam logic [11:0] SLOT_OFF     = 12'h008;
	localparam logic [11:0] PME_OFF      = 12'h00C;
	localparam logic [11:0] LINKCAP_OFF  = 12'h010;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	// control bit positions
	localparam int CB_PM_SCI   = 0;
	localparam int CB_PM_SMI   = 1;
	localparam int CB_HP_SCI   = 2;
	localparam int CB_HP_SMI   = 3;
	localparam int CB_POST     = 4;
	localparam int CB_PDC_IE   = 5;
	localparam int CB_HP_IE    = 6;
	localparam int CB_PTM      = 7;
	localparam int CB_PME_IE   = 8;
	// status bit positions
	localparam int SB_PM_SCI   = 0;
	localparam int SB_PM_SMI   = 1;
	localparam int SB_HP_SCI   = 2;
	localparam int SB_HP_PD    = 3;
	localparam int SB_HP_LA    = 4;
	localparam int SB_PDC      = 5;
	localparam int SB_LFAIL    = 6;
	localparam int SB_PME      = 7;
	localparam int SB_PME_PEND = 8;
	localparam int STATUS_W    = 9;
	// post-code io window
	localparam logic [15:0] POST_LO = 16'h0080;
	localparam logic [15:0] POST_HI = 16'h008F;
	// clock rate and L1 exit latency, in us and encoded per the link capability field
	localparam int CLK_MHZ             = 40;
	localparam int L1_EXIT_SEPARATE_REFCLK_MODE_US     = 10;
	localparam logic [2:0] L1_EXIT_NORMAL = 3'h2;
	localparam logic [2:0] L1_EXIT_SEPARATE_REFCLK_MODE   = 3'h4;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [31:0] data;
	} io_req_t;

	typedef struct packed {
		logic aspm_l0s_allowed;
		logic lower_skp_allowed;
		logic [2:0] l1_exit_lat;
		logic ptm_enable;
	} link_cfg_t;
endpackage

// File: rp_event_routing.sv
/*
 * Root-port side-band event routing: PM and hot-plug status, SCI/SMI
 * routing, presence tracking, POST-code I/O claim, separate-refclk limits.
 * Assumes physical-layer events arrive as one-cycle pulses on pclk and
 * that the separate-refclk strap is stable around reset release.
 */
// The address map and the APB interface to the registers were chosen for this implementation.
//
// Contract
// R01: pm event with pm sci routing enabled sets pm sci status.
// R02: pm event with pm smi routing enabled sets pm smi status, asserts smi.
// R03: pm smi status is set independent of interrupt or sci enables.
// R04: with post decode enabled, claim io cycles at 80h through 8Fh.
// R05: post window claim ignores io base/limit and io space enable.
// R06: claimed post cycles go to the link unchanged, no local storage.
// R07: downstream device returns last written value on post reads.
// R08: separate refclk mode comes only from a strap sampled at reset release.
// R09: separate refclk mode disallows the L0s low-power substate.
// R10: separate refclk mode reports L1 exit latency of 10 us.
// R11: reduced-rate skp ordered sets are never generated or accepted.
// R12: insertion sets presence state and presence changed flag.
// R13: removal clears presence state and sets presence changed flag.
// R14: presence change interrupts only when both enables are set.
// R15: enabled hot-plug event with hp sci routing sets hp sci status.
// R16: hp smi routing sets presence smi status or link-active smi status.
// R17: either hot-plug smi status asserts smi regardless of other enables.
// R18: each lane corrects its own inverted polarity, no setting needed.
// R19: precision time measurement has a per-port enable.
// R20: link down event asserts the link failure indicator.
// R21: endpoint sends ltr initially and whenever tolerance changes.
// R22: first pme sets pme status, logs requester id, later ones pending.
// R23: status bits stay set until written one; irqs follow enabled status. Pme pending also clears when a pme status w1c re-arms it and no pme arrives.
`timescale 1ns/1ps
module rp_event_routing #(
	parameter int LANES = 4
) (
	input  wire logic                    pclk,           // core clock
	input  wire logic                    presetn,        // async reset, low
	input  wire logic                    psel,           // apb select
	input  wire logic                    penable,        // apb enable
	input  wire logic                    pwrite,         // apb direction
	input  wire logic [11:0]             paddr,          // apb byte address
	input  wire logic [31:0]             pwdata,         // apb write data
	input  wire logic [3:0]              pstrb,          // apb byte strobes
	output logic                         pready,         // apb ready
	output logic [31:0]                  prdata,         // apb read data
	output logic                         pslverr,        // apb error
	input  wire logic                    separate_refclk_mode_strap,     // separate refclk strap
	input  wire logic                    pm_event,       // pm event pulse
	input  wire logic                    pme_msg,        // pm_pme message pulse
	input  wire logic [15:0]             pme_req_id,     // requester id of message
	input  wire logic                    phy_insert,     // insertion pulse
	input  wire logic                    phy_remove,     // removal pulse
	input  wire logic                    link_act_chg,   // link-active change pulse
	input  wire logic                    link_down,      // link-down event pulse
	input  wire logic                    skp_low_rx,     // reduced-rate skp seen
	input  wire logic [LANES-1:0]        lane_rx_inv,    // lane sees inverted symbols in training
	input  wire logic                    lane_training,  // initial training active
	input  wire rp_event_pkg::io_req_t   io_up,          // upstream io request
	input  wire logic                    io_bridge_hit,  // base/limit window hit
	input  wire logic                    io_space_en,    // io space enable
	output rp_event_pkg::io_req_t        io_link,        // request sent to link
	output logic                         io_claim,       // io cycle claimed
	output logic [LANES-1:0]             lane_polarity,  // per-lane invert control
	output rp_event_pkg::link_cfg_t      link_cfg,       // link capability view
	output logic                         skp_low_accept, // reduced skp accepted
	output logic                         sys_mgmt_irq_n, // smi, active low
	output logic                         sci_irq,        // acpi control interrupt
	output logic                         port_irq,       // normal port interrupt
	output logic                         link_fail_indicator // link-down debug
);
	import rp_event_pkg::*;

	logic [31:0]         ctrl_reg, ctrl_next;
	logic [STATUS_W-1:0] sts_reg, sts_next;
	logic                slot_presence_state, presence_next;
	logic [15:0]         rid_reg, rid_next;
	logic                separate_refclk_mode_reg;
	logic                separate_refclk_mode_taken_reg;
	logic [LANES-1:0]    pol_reg;
	io_req_t             io_link_reg;
	logic                claim_reg;
	logic [31:0]         prdata_reg;

	wire pm_sci_route_en        = ctrl_reg[CB_PM_SCI];
	wire pm_smi_route_en        = ctrl_reg[CB_PM_SMI];
	wire hp_sci_route_en        = ctrl_reg[CB_HP_SCI];
	wire hp_smi_route_en        = ctrl_reg[CB_HP_SMI];
	wire post_code_decode_en    = ctrl_reg[CB_POST];
	wire presence_change_irq_en = ctrl_reg[CB_PDC_IE];
	wire hotplug_irq_en         = ctrl_reg[CB_HP_IE];
	wire pme_irq_en             = ctrl_reg[CB_PME_IE];
	wire pm_sci_sts             = sts_reg[SB_PM_SCI];
	wire pm_smi_sts             = sts_reg[SB_PM_SMI];
	wire hp_sci_sts             = sts_reg[SB_HP_SCI];
	wire hp_presence_smi_sts    = sts_reg[SB_HP_PD];
	wire hp_linkact_smi_sts     = sts_reg[SB_HP_LA];
	wire presence_changed_flag  = sts_reg[SB_PDC];

	// apb decode, zero wait state
	wire apb_acc  = psel & penable;
	wire apb_wr   = apb_acc & pwrite;
	wire hit_ctrl = paddr == CTRL_OFF;
	wire hit_sts  = paddr == STATUS_OFF;
	wire hit_slot = paddr == SLOT_OFF;
	wire hit_pme  = paddr == PME_OFF;
	wire hit_lcap = paddr == LINKCAP_OFF;
	wire mapped   = hit_ctrl | hit_sts | hit_slot | hit_pme | hit_lcap;
	wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [STATUS_W-1:0] w1c = (apb_wr & hit_sts) ? (pwdata[STATUS_W-1:0] & strb_mask[STATUS_W-1:0])
	                                             : {STATUS_W{1'b0}};

	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~mapped;
	assign prdata  = prdata_reg;

	// hot-plug event qualification
	wire pd_event     = phy_insert | phy_remove;
	wire pd_irq_event = pd_event & presence_change_irq_en & hotplug_irq_en; // R14
	wire hp_enabled   = pd_irq_event | (link_act_chg & hotplug_irq_en);

	// pme first message versus pending; a w1c of the status with pending
	// queued re-arms status so the pending message is not dropped
	wire pme_sts_clr = w1c[SB_PME] & sts_reg[SB_PME];
	wire pme_first   = pme_msg & ~sts_reg[SB_PME];
	wire pme_later   = pme_msg & sts_reg[SB_PME] & ~pme_sts_clr;
	wire pme_rearm   = pme_sts_clr & (sts_reg[SB_PME_PEND] | pme_msg);

	// set wins over write-one-clear on every flag
	wire [STATUS_W-1:0] set_vec = {
		pme_later,                                   // pending
		pme_first | pme_rearm,                       // R22
		link_down,                                   // R20
		pd_event,                                    // R12 R13
		link_act_chg & hp_smi_route_en,              // R16
		pd_event & hp_smi_route_en,                  // R16
		hp_enabled & hp_sci_route_en,                // R15
		pm_event & pm_smi_route_en,                  // R02 R03
		pm_event & pm_sci_route_en                   // R01
	};

	always_comb begin
		sts_next = (sts_reg & ~w1c) | set_vec; // R23
		if (pme_rearm & ~pme_msg) begin
			sts_next[SB_PME_PEND] = 1'b0;
		end
	end

	assign rid_next = (pme_first | (pme_rearm & pme_msg)) ? pme_req_id : rid_reg; // R22

	// insertion and removal never coincide; insertion wins if they do
	assign presence_next = phy_insert ? 1'b1 : (phy_remove ? 1'b0 : slot_presence_state); // R12 R13

	assign ctrl_next = (apb_wr & hit_ctrl) ? ((ctrl_reg & ~strb_mask) | (pwdata & strb_mask)) : ctrl_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg            <= CTRL_RST;
			sts_reg             <= '0;
			slot_presence_state <= 1'b0;
			rid_reg             <= 16'h0000;
		end else begin
			ctrl_reg            <= ctrl_next;
			sts_reg             <= sts_next;
			slot_presence_state <= presence_next;
			rid_reg             <= rid_next;
		end
	end

	// strap caught once after release; later changes are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			separate_refclk_mode_reg       <= 1'b0;
			separate_refclk_mode_taken_reg <= 1'b0;
		end else if (!separate_refclk_mode_taken_reg) begin
			separate_refclk_mode_reg       <= separate_refclk_mode_strap; // R08
			separate_refclk_mode_taken_reg <= 1'b1;
		end
	end

	// interrupt outputs follow enabled status; smi ignores sci/irq enables
	assign sys_mgmt_irq_n = ~(pm_smi_sts | hp_presence_smi_sts | hp_linkact_smi_sts); // R02 R17
	assign sci_irq        = pm_sci_sts | hp_sci_sts; // R23
	assign port_irq       = (presence_changed_flag & presence_change_irq_en & hotplug_irq_en) // R14
	                      | (sts_reg[SB_PME] & pme_irq_en); // R22
	assign link_fail_indicator = sts_reg[SB_LFAIL]; // R20

	// post window: base/limit and io space enable deliberately not consulted
	function automatic logic in_post_window(input logic [15:0] a);
		return (a >= POST_LO) && (a <= POST_HI);
	endfunction

	wire post_hit = io_up.valid & post_code_decode_en & in_post_window(io_up.addr); // R04 R05
	wire norm_hit = io_up.valid & io_bridge_hit & io_space_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_link_reg <= '0;
			claim_reg   <= 1'b0;
		end else begin
			io_link_reg <= (post_hit | norm_hit) ? io_up : '0; // R06
			claim_reg   <= post_hit | norm_hit;
		end
	end
	assign io_link  = io_link_reg;
	assign io_claim = claim_reg;

	// per-lane polarity latched only during initial training
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pol_reg[g] <= 1'b0;
				end else if (lane_training && lane_rx_inv[g]) begin
					pol_reg[g] <= ~pol_reg[g]; // R18
				end
			end
		end
	endgenerate
	assign lane_polarity = pol_reg;

	always_comb begin
		link_cfg.aspm_l0s_allowed  = ~separate_refclk_mode_reg; // R09
		link_cfg.lower_skp_allowed = 1'b0; // R11
		link_cfg.l1_exit_lat       = separate_refclk_mode_reg ? L1_EXIT_SEPARATE_REFCLK_MODE : L1_EXIT_NORMAL; // R10
		link_cfg.ptm_enable        = ctrl_reg[CB_PTM]; // R19
	end
	assign skp_low_accept = skp_low_rx & 1'b0; // R11

	// read mux registered so data leaves a flip-flop
	wire [31:0] rd_val = hit_ctrl ? ctrl_reg
	                   : hit_sts  ? {{(32-STATUS_W){1'b0}}, sts_reg}
	                   : hit_slot ? {31'h0, slot_presence_state}
	                   : hit_pme  ? {16'h0000, rid_reg}
	                   : hit_lcap ? {26'h0, link_cfg}
	                   : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= rd_val;
		end
	end

	a_pm_smi_set: assert property (@(posedge pclk) disable iff (!presetn) // R02
		(pm_event && pm_smi_route_en) |=> pm_smi_sts ##0 !sys_mgmt_irq_n)
		else $error("pm smi not raised");
	a_pm_sci_set: assert property (@(posedge pclk) disable iff (!presetn) // R01
		(pm_event && pm_sci_route_en) |=> pm_sci_sts)
		else $error("pm sci not raised");
	a_smi_indep: assert property (@(posedge pclk) disable iff (!presetn) // R03
		(pm_event && pm_smi_route_en && !pm_sci_route_en) |=> !sys_mgmt_irq_n)
		else $error("smi depends on sci enable");
	a_post_claim: assert property (@(posedge pclk) disable iff (!presetn) // R04 R05 R06
		(io_up.valid && post_code_decode_en && io_up.addr >= 16'h0080 && io_up.addr <= 16'h008F)
		|=> io_claim && io_link == $past(io_up))
		else $error("post cycle not forwarded");
	a_separate_refclk_mode_l0s: assert property (@(posedge pclk) disable iff (!presetn) // R09 R10
		separate_refclk_mode_reg |-> !link_cfg.aspm_l0s_allowed && link_cfg.l1_exit_lat == L1_EXIT_SEPARATE_REFCLK_MODE)
		else $error("separate_refclk_mode limits not applied");
	a_separate_refclk_mode_static: assert property (@(posedge pclk) disable iff (!presetn) // R08
		separate_refclk_mode_taken_reg |=> $stable(separate_refclk_mode_reg))
		else $error("separate_refclk_mode mode changed");
	a_insert_pres: assert property (@(posedge pclk) disable iff (!presetn) // R12
		phy_insert |=> slot_presence_state && presence_changed_flag)
		else $error("insertion not recorded");
	a_remove_pres: assert property (@(posedge pclk) disable iff (!presetn) // R13
		(phy_remove && !phy_insert) |=> !slot_presence_state && presence_changed_flag)
		else $error("removal not recorded");
	a_pd_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // R14
		port_irq && !sts_reg[SB_PME] |-> presence_change_irq_en && hotplug_irq_en)
		else $error("presence irq without enables");
	a_hp_smi: assert property (@(posedge pclk) disable iff (!presetn) // R16 R17
		(link_act_chg && hp_smi_route_en) |=> hp_linkact_smi_sts ##1 (!sys_mgmt_irq_n || $past(w1c[SB_HP_LA])))
		else $error("link active smi missing");
	a_hp_sci: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(pd_irq_event && hp_sci_route_en) |=> hp_sci_sts)
		else $error("hp sci not raised");
	a_link_fail: assert property (@(posedge pclk) disable iff (!presetn) // R20
		link_down |=> link_fail_indicator)
		else $error("link down not flagged");
	a_sticky_sts: assert property (@(posedge pclk) disable iff (!presetn) // R23
		(pm_smi_sts && !w1c[SB_PM_SMI]) |=> pm_smi_sts)
		else $error("status dropped without clear");
	a_pme_first: assert property (@(posedge pclk) disable iff (!presetn) // R22
		(pme_msg && !sts_reg[SB_PME]) |=> sts_reg[SB_PME] && rid_reg == $past(pme_req_id))
		else $error("pme first not logged");

	a_sci_no_route: assert property (@(posedge pclk) disable iff (!presetn) // R01
		(pm_event && !pm_sci_route_en && !pm_sci_sts)
		|=> !pm_sci_sts)
		else $error("pm sci set without routing");

	a_smi_no_route: assert property (@(posedge pclk) disable iff (!presetn) // R02
		(pm_event && !pm_smi_route_en && sys_mgmt_irq_n && !pd_event && !link_act_chg)
		|=> sys_mgmt_irq_n)
		else $error("smi raised without routing");

	a_hp_pd_smi: assert property (@(posedge pclk) disable iff (!presetn) // R16 R17
		(pd_event && hp_smi_route_en)
		|=> hp_presence_smi_sts && !sys_mgmt_irq_n)
		else $error("presence smi missing");

	a_hp_la_sci: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(link_act_chg && hotplug_irq_en && hp_sci_route_en)
		|=> hp_sci_sts)
		else $error("link active sci missing");

	a_pd_sci_gate: assert property (@(posedge pclk) disable iff (!presetn) // R14 R15
		(pd_event && !link_act_chg && !hp_sci_sts && !(presence_change_irq_en && hotplug_irq_en))
		|=> !hp_sci_sts)
		else $error("hp sci without irq enables");

	a_pd_irq_set: assert property (@(posedge pclk) disable iff (!presetn) // R14
		(pd_event && presence_change_irq_en && hotplug_irq_en && !apb_wr)
		|=> port_irq)
		else $error("presence irq missing");

	a_presence_hold: assert property (@(posedge pclk) disable iff (!presetn) // R12 R13
		(!phy_insert && !phy_remove)
		|=> $stable(slot_presence_state))
		else $error("presence changed without event");

	a_post_outside: assert property (@(posedge pclk) disable iff (!presetn) // R04
		(io_up.valid && !(io_bridge_hit && io_space_en) && !(post_code_decode_en && in_post_window(io_up.addr)))
		|=> !io_claim && !io_link.valid)
		else $error("io cycle claimed outside window");

	a_io_idle: assert property (@(posedge pclk) disable iff (!presetn) // R06
		!io_up.valid
		|=> !io_claim && !io_link.valid)
		else $error("link request without upstream cycle");

	a_separate_refclk_mode_normal: assert property (@(posedge pclk) disable iff (!presetn) // R09 R10
		!separate_refclk_mode_reg
		|-> link_cfg.aspm_l0s_allowed && link_cfg.l1_exit_lat == L1_EXIT_NORMAL)
		else $error("common clock limits wrong");

	a_pol_hold: assert property (@(posedge pclk) disable iff (!presetn) // R18
		!lane_training
		|=> $stable(lane_polarity))
		else $error("polarity moved outside training");

	a_pol_flip: assert property (@(posedge pclk) disable iff (!presetn) // R18
		(lane_training && lane_rx_inv[0])
		|=> lane_polarity[0] != $past(lane_polarity[0]))
		else $error("lane polarity not corrected");

	a_ptm_write: assert property (@(posedge pclk) disable iff (!presetn) // R19
		(apb_wr && hit_ctrl && pstrb[0])
		|=> link_cfg.ptm_enable == $past(pwdata[CB_PTM]))
		else $error("ptm enable not written");

	a_link_fail_hold: assert property (@(posedge pclk) disable iff (!presetn) // R20 R23
		(link_fail_indicator && !w1c[SB_LFAIL])
		|=> link_fail_indicator)
		else $error("link fail dropped without clear");

	a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn) // R23
		(w1c[SB_LFAIL] && !link_down)
		|=> !link_fail_indicator)
		else $error("link fail not cleared");

	a_pme_pend: assert property (@(posedge pclk) disable iff (!presetn) // R22
		(pme_msg && sts_reg[SB_PME] && !w1c[SB_PME])
		|=> sts_reg[SB_PME_PEND] && $stable(rid_reg))
		else $error("later pme not pending");

	a_pme_rearm: assert property (@(posedge pclk) disable iff (!presetn) // R22 R23
		(w1c[SB_PME] && sts_reg[SB_PME] && sts_reg[SB_PME_PEND] && !pme_msg)
		|=> sts_reg[SB_PME] && !sts_reg[SB_PME_PEND])
		else $error("pending pme lost on clear");

	a_rid_hold: assert property (@(posedge pclk) disable iff (!presetn) // R22
		!pme_msg
		|=> $stable(rid_reg))
		else $error("requester id moved without message");

	a_ctrl_guard: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_wr && !hit_ctrl)
		|=> $stable(ctrl_reg))
		else $error("control changed by other write");

	a_read_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_ctrl)
		|=> prdata == $past(ctrl_reg))
		else $error("control read data wrong");
endmodule

// File: post_card_model.sv
/*
 * Link-side model of a POST-code card behind the port.
 * Assumes forwarded io requests arrive on io_link as one-cycle valid pulses.
 */
`timescale 1ns/1ps
module post_card_model (
	input  wire logic                  pclk,    // core clock
	input  wire logic                  presetn, // async reset, low
	input  wire rp_event_pkg::io_req_t io_link, // forwarded request
	input  wire logic [9:0]            ltr_tol, // current latency tolerance
	output logic [31:0]                rd_val,  // answer to the last read
	output logic                       ltr_msg  // ltr message to the port
);
	import rp_event_pkg::*;
	// no reset: an unwritten port reads unknown, as real hardware would
	logic [31:0] mem [16];
	logic        booted_reg;
	logic [9:0]  tol_reg;

	// one report at boot, then one per tolerance change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			booted_reg <= 1'b0;
			tol_reg    <= 10'h000;
			ltr_msg    <= 1'b0;
		end else begin
			booted_reg <= 1'b1;
			tol_reg    <= ltr_tol;
			ltr_msg    <= !booted_reg || (ltr_tol != tol_reg);
		end
	end

	always_ff @(posedge pclk) begin
		if (io_link.valid && io_link.write) begin
			mem[io_link.addr[3:0]] <= io_link.data;
		end
		if (io_link.valid && !io_link.write) begin
			rd_val <= mem[io_link.addr[3:0]];
		end
	end
endmodule

// File: pcie_root_port_event_routing_bench.sv
/*
 * Self-checking bench for the root-port event routing block.
 * Assumes a zero-wait APB slave and one-cycle event pulses on pclk.
 */
`timescale 1ns/1ps
module pcie_root_port_event_routing_bench;
	import rp_event_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, separate_refclk_mode_strap, lane_training;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, rd_val;
	logic        pready, pslverr, rerr, io_claim, skp_low_accept;
	logic        sys_mgmt_irq_n, sci_irq, port_irq, link_fail_indicator;
	logic [6:0]  ev;
	logic [15:0] pme_req_id;
	logic [3:0]  lane_rx_inv, lane_polarity;
	logic [9:0]  ltr_tol;
	logic        ltr_msg, bhit, ioen;
	io_req_t     io_up, io_link;
	link_cfg_t   link_cfg;
	int          err_total, checks;

	always #12.5 pclk = ~pclk;

	rp_event_routing #(.LANES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .separate_refclk_mode_strap(separate_refclk_mode_strap), .pm_event(ev[0]), .pme_msg(ev[1]),
		.pme_req_id(pme_req_id), .phy_insert(ev[2]), .phy_remove(ev[3]), .link_act_chg(ev[4]),
		.link_down(ev[5]), .skp_low_rx(ev[6]), .lane_rx_inv(lane_rx_inv), .lane_training(lane_training),
		.io_up(io_up), .io_bridge_hit(bhit), .io_space_en(ioen), .io_link(io_link), .io_claim(io_claim),
		.lane_polarity(lane_polarity), .link_cfg(link_cfg), .skp_low_accept(skp_low_accept),
		.sys_mgmt_irq_n(sys_mgmt_irq_n), .sci_irq(sci_irq), .port_irq(port_irq),
		.link_fail_indicator(link_fail_indicator));

	post_card_model partner (.pclk(pclk), .presetn(presetn), .io_link(io_link), .ltr_tol(ltr_tol),
		.rd_val(rd_val), .ltr_msg(ltr_msg));

	task automatic end_of_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_of_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rdat, x);
	endtask

	task automatic pulse(input logic [6:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= '0;
		@(negedge pclk);
	endtask

	task automatic io(input logic w, input logic [15:0] a, input logic c);
		io_req_t q;
		q = '{valid: 1'b1, write: w, addr: a, data: {16'hC0DE, a}};
		@(posedge pclk);
		io_up <= q;
		@(posedge pclk);
		io_up <= '0;
		@(negedge pclk);
		chk(io_claim, c);
		chk(io_link, c ? q : '0);
	endtask

	task automatic rst(input logic s);
		separate_refclk_mode_strap <= s;
		presetn    <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn    <= 1'b1;
		// the strap is taken at the first edge after release
		@(posedge pclk);
		@(negedge pclk);
	endtask

	initial begin
		#100000;
		err_total++;
		end_of_test();
	end

	initial begin
		{pclk, psel, penable, pwrite, separate_refclk_mode_strap, lane_training, ev} = '0;
		{paddr, pwdata, pme_req_id, lane_rx_inv, io_up, ltr_tol, bhit, ioen} = '0;
		presetn = 1'b0;
		err_total = 0;
		checks = 0;
		rst(1'b0);
		chk(sys_mgmt_irq_n, 1'b1);
		chk(ltr_msg, 1'b1);
		chk(link_cfg, {1'b1, 1'b0, L1_EXIT_NORMAL, 1'b0});
		rd(CTRL_OFF, CTRL_RST);
		rd(STATUS_OFF, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(CTRL_OFF, m);
			pulse(7'h01);
			chk(sys_mgmt_irq_n, !m[1]);
			chk(sci_irq, m[0]);
			rd(STATUS_OFF, m);
			wr(STATUS_OFF, 32'h1FF);
		end
		chk(sys_mgmt_irq_n, 1'b1);
		wr(CTRL_OFF, 32'h6C);
		pulse(7'h04);
		rd(SLOT_OFF, 32'h1);
		rd(STATUS_OFF, 32'h2C);
		chk({port_irq, sys_mgmt_irq_n}, 2'b10);
		wr(STATUS_OFF, 32'h08);
		rd(STATUS_OFF, 32'h24);
		chk(sys_mgmt_irq_n, 1'b1);
		wr(STATUS_OFF, 32'h1FF);
		wr(CTRL_OFF, 32'h08);
		pulse(7'h08);
		rd(SLOT_OFF, 32'h0);
		rd(STATUS_OFF, 32'h28);
		chk({port_irq, sys_mgmt_irq_n}, 2'b00);
		pulse(7'h10);
		rd(STATUS_OFF, 32'h38);
		wr(CTRL_OFF, 32'h28);
		chk(port_irq, 1'b0);
		wr(CTRL_OFF, 32'h68);
		chk(port_irq, 1'b1);
		wr(STATUS_OFF, 32'h1FF);
		// decode on, io space on, bridge window missed
		wr(CTRL_OFF, 32'h10);
		ioen <= 1'b1;
		io(1'b1, 16'h0080, 1'b1);
		io(1'b1, 16'h008F, 1'b1);
		io(1'b0, 16'h007F, 1'b0);
		io(1'b0, 16'h0090, 1'b0);
		io(1'b0, 16'h0080, 1'b1);
		@(negedge pclk);
		chk(rd_val, 32'hC0DE0080);
		wr(CTRL_OFF, 32'h0);
		bhit <= 1'b1;
		io(1'b0, 16'h0300, 1'b1);
		ioen <= 1'b0;
		io(1'b0, 16'h0300, 1'b0);
		bhit <= 1'b0;
		io(1'b1, 16'h0085, 1'b0);
		pulse(7'h20);
		chk(link_fail_indicator, 1'b1);
		rd(STATUS_OFF, 32'h40);
		wr(STATUS_OFF, 32'h40);
		chk(link_fail_indicator, 1'b0);
		wr(CTRL_OFF, 32'h100);
		pme_req_id <= 16'h1234;
		pulse(7'h02);
		rd(STATUS_OFF, 32'h80);
		rd(PME_OFF, 32'h1234);
		chk(port_irq, 1'b1);
		pme_req_id <= 16'h5678;
		pulse(7'h02);
		rd(STATUS_OFF, 32'h180);
		rd(PME_OFF, 32'h1234);
		wr(STATUS_OFF, 32'h80);
		rd(STATUS_OFF, 32'h80);
		wr(CTRL_OFF, 32'h80);
		chk(link_cfg.ptm_enable, 1'b1);
		wr(CTRL_OFF, 32'h0);
		chk(link_cfg.ptm_enable, 1'b0);
		lane_training <= 1'b1;
		@(posedge pclk);
		lane_rx_inv <= 4'h5;
		@(posedge pclk);
		lane_rx_inv   <= 4'h0;
		lane_training <= 1'b0;
		@(posedge pclk);
		lane_rx_inv <= 4'hA;
		@(posedge pclk);
		lane_rx_inv <= 4'h0;
		@(negedge pclk);
		chk(lane_polarity, 4'h5);
		ltr_tol <= 10'h005;
		@(negedge pclk);
		chk(ltr_msg, 1'b1);
		@(negedge pclk);
		chk(ltr_msg, 1'b0);
		apb(1'b0, 12'h020, 32'h0);
		chk({rerr, rdat}, {1'b1, 32'h0});
		// second reset with the strap set selects separate refclk mode
		rst(1'b1);
		chk(ltr_msg, 1'b1);
		chk(link_cfg, {1'b0, 1'b0, L1_EXIT_SEPARATE_REFCLK_MODE, 1'b0});
		pulse(7'h40);
		chk(skp_low_accept, 1'b0);
		separate_refclk_mode_strap <= 1'b0;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk(link_cfg.l1_exit_lat, L1_EXIT_SEPARATE_REFCLK_MODE);
		end_of_test();
	end
endmodule
